// ===== shared/fspd_pkg.sv
// fspd_pkg: constants and types for the status and write-protection block.
// assumes a 4 MB array addressed by 22-bit byte addresses and an AHB-Lite register bus.
package fspd_pkg;

  // array geometry
  localparam int          ADDR_W       = 22;
  localparam logic [22:0] ARRAY_BYTES  = 23'h400000;  // 4 MB
  localparam logic [22:0] BLOCK_BYTES  = 23'h010000;  // 64 KB
  localparam logic [22:0] SECTOR_BYTES = 23'h001000;  // 4 KB
  localparam int          LOCK_W       = 3;
  localparam int          RANGE_W      = 3;

  // register byte offsets
  localparam logic [7:0] REG_STATUS   = 8'h00;
  localparam logic [7:0] REG_CMD      = 8'h04;
  localparam logic [7:0] REG_OP_START = 8'h08;
  localparam logic [7:0] REG_OP_END   = 8'h0c;
  localparam logic [7:0] REG_OP_CTRL  = 8'h10;
  localparam logic [7:0] REG_RESULT   = 8'h14;
  localparam logic [7:0] REG_LINK     = 8'h18;

  // status word bit positions
  localparam int BIT_PAUSED      = 15;
  localparam int BIT_INVERT      = 14;
  localparam int LOCK_LSB        = 11;
  localparam int BIT_FOUR_LANE   = 9;
  localparam int BIT_STATUS_LOCK = 7;
  localparam int BIT_SMALL       = 6;
  localparam int BIT_LOW_END     = 5;
  localparam int RANGE_LSB       = 2;
  localparam int BIT_WEL         = 1;

  // op control, result and link fields
  localparam int BIT_OP_GO     = 0;
  localparam int BIT_OP_SECREG = 1;
  localparam int SEC_IDX_LSB   = 2;
  localparam int BIT_RES_DONE  = 0;
  localparam int BIT_RES_OK    = 1;
  localparam int BIT_RES_BAD   = 2;
  localparam int BIT_LINK_DRV  = 8;
  localparam int BIT_LINK_PAUS = 9;
  localparam int BIT_LINK_GRD  = 10;

  // command codes written to the command register
  localparam logic [7:0] CMD_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_SUSPEND       = 8'h75;
  localparam logic [7:0] CMD_RESUME        = 8'h7a;

  // protect-range field codes
  localparam logic [2:0] RANGE_NONE = 3'h0;
  localparam logic [2:0] RANGE_ALL  = 3'h7;

  // one contiguous protected window
  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] lo;
    logic [ADDR_W-1:0] hi;
  } fspd_range_type;

endpackage : fspd_pkg

// ===== hw/fspd_status_protect.sv
// fspd_status_protect: status fields, lock bits, four-lane mode and range protection.
// assumes an AHB-Lite master on clk, pins and serial clock asynchronous to clk.
// Function
// RULE1: suspend command 75h sets read-only paused flag at status bit 15.
// RULE2: resume command 7Ah or power-up reset clears the paused flag.
// RULE3: three lock bits at status 13..11, reset to zero, all unlocked.
// RULE4: each lock bit may be set by status write and never clears; here rst_n clears otpLockBits_ff to zero.
// RULE5: locked security register refuses every program or erase.
// RULE6: four-lane bit at status 9 defaults 0; guard and pause pins active.
// RULE7: four-lane set turns guard and pause pins into data lines two, three.
// RULE8: host must not set four-lane when guard or pause pins are strapped.
// RULE9: without small granule, range codes protect none, 64KB multiples, or all.
// RULE10: with small granule, codes protect 4, 8, 16 or 32KB at one end.
// RULE11: program or erase touching any protected address is ignored, array untouched.
// RULE12: three protect-range bits at status 4..2, reset zero, nothing protected.
// RULE13: invert bit at status 14 swaps protected and writable regions.
// RULE14: host issues write enable before status write, program or erase.
// RULE15: whole start..end span is checked against protection before any change.
//
// Implementation choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module fspd_status_protect
  import fspd_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // serial link pins
  input  wire logic        serialClk,
  input  wire logic        guardPin_n,
  input  wire logic        pausePin_n,
  input  wire logic        dataLineTwoIn,
  output logic             dataLineTwoOut,
  output logic             dataLineTwoOe_n,
  input  wire logic        dataLineThreeIn,
  output logic             dataLineThreeOut,
  output logic             dataLineThreeOe_n,
  // accepted array operation
  output logic             arrayWriteGo,
  output logic [ADDR_W-1:0] arrayStart,
  output logic [ADDR_W-1:0] arrayEnd
);

  // protected window from the range fields
  function automatic fspd_range_type decode_range(input logic [2:0] code,
                                                  input logic       fineGrain,
                                                  input logic       lowEnd,
                                                  input logic       invert);
    logic [22:0]    size;
    logic [2:0]     shift;
    fspd_range_type r;
    size  = '0;
    shift = '0;
    r     = '0;
    if (code == RANGE_ALL) begin
      size = ARRAY_BYTES;
    end else if (code != RANGE_NONE && fineGrain) begin
      shift = (code >= 3'h4) ? 3'h3 : code - 3'h1; // 10x both give 32KB
      size  = SECTOR_BYTES << shift;
    end else if (code != RANGE_NONE) begin
      shift = code - 3'h1;
      size  = BLOCK_BYTES << shift;
    end
    if (!invert) begin
      r.valid = (size != '0);
      r.lo    = lowEnd ? '0 : ADDR_W'(ARRAY_BYTES - size);
      r.hi    = lowEnd ? ADDR_W'(size - 23'h1) : ADDR_W'(ARRAY_BYTES - 23'h1);
    end else begin
      r.valid = (size != ARRAY_BYTES);
      r.lo    = lowEnd ? ADDR_W'(size) : '0;
      r.hi    = lowEnd ? ADDR_W'(ARRAY_BYTES - 23'h1) : ADDR_W'(ARRAY_BYTES - size - 23'h1);
    end
    return r;
  endfunction : decode_range

  // status fields
  logic              pausedOpFlag_ff;
  logic              invertProtection_ff;
  logic [LOCK_W-1:0] otpLockBits_ff;
  logic              fourLaneEnable_ff;
  logic              statusLockModeLow_ff;
  logic              smallGranuleSelect_ff;
  logic              protectFromLowEnd_ff;
  logic [RANGE_W-1:0] protectRange_ff;
  logic              writeEnableLatch_ff;
  // operation and link registers
  logic [ADDR_W-1:0] opStart_ff;
  logic [ADDR_W-1:0] opEnd_ff;
  logic [2:0]        result_ff;
  logic              arrayGo_ff;
  logic [ADDR_W-1:0] arrayStart_ff;
  logic [ADDR_W-1:0] arrayEnd_ff;
  logic [1:0]        txBits_ff;
  logic              linkDrive_ff;
  logic [7:0]        rxShift_ff;
  logic              lineTwoOut_ff;
  logic              lineThreeOut_ff;
  // bus phase registers
  logic              wrPend_ff;
  logic              rdPend_ff;
  logic [7:0]        phaseAddr_ff;
  logic [31:0]       rdata_ff;
  // synchronisers
  logic [4:0]        syncA_ff;
  logic [4:0]        syncB_ff;
  logic              sclkPrev_ff;

  // bus decode
  wire        addrPhase = hsel & htrans[1] & hready;
  wire        wrStrobe  = wrPend_ff;
  wire        regStatus = wrStrobe && phaseAddr_ff == REG_STATUS;
  wire        regCmd    = wrStrobe && phaseAddr_ff == REG_CMD;
  wire        regStart  = wrStrobe && phaseAddr_ff == REG_OP_START;
  wire        regEnd    = wrStrobe && phaseAddr_ff == REG_OP_END;
  wire        regOpCtl  = wrStrobe && phaseAddr_ff == REG_OP_CTRL;
  wire        regLink   = wrStrobe && phaseAddr_ff == REG_LINK;
  wire [7:0]  cmdCode   = hwdata[7:0];

  // synchronised pins
  wire sclkS       = syncB_ff[0];
  wire guardS_n    = syncB_ff[1];
  wire pauseS_n    = syncB_ff[2];
  wire lineTwoS    = syncB_ff[3];
  wire lineThreeS  = syncB_ff[4];
  wire sclkRise    = sclkS & ~sclkPrev_ff;
  wire sclkFall    = ~sclkS & sclkPrev_ff;

  // pin function by lane mode
  wire pauseActive = ~fourLaneEnable_ff & ~pauseS_n;                 // [RULE6] [RULE7]
  wire guardBlock  = ~fourLaneEnable_ff & statusLockModeLow_ff & ~guardS_n; // [RULE6]

  // commands and status write
  wire cmdSuspend  = regCmd && cmdCode == CMD_SUSPEND;
  wire cmdResume   = regCmd && cmdCode == CMD_RESUME;
  wire cmdWen      = regCmd && cmdCode == CMD_WRITE_ENABLE;
  wire cmdWdis     = regCmd && cmdCode == CMD_WRITE_DISABLE;
  wire statusTake  = regStatus & writeEnableLatch_ff & ~guardBlock;

  // protection check of the requested operation
  fspd_range_type prot;
  assign prot = decode_range(protectRange_ff, smallGranuleSelect_ff,
                             protectFromLowEnd_ff, invertProtection_ff); // [RULE9] [RULE10] [RULE13]
  wire       opGo      = regOpCtl & hwdata[BIT_OP_GO];
  wire       opSecReg  = hwdata[BIT_OP_SECREG];
  wire [1:0] secIdx    = hwdata[SEC_IDX_LSB +: 2];
  wire [LOCK_W:0] lockVec = {otpLockBits_ff, 1'b1};  // index 0 reads as locked
  wire       secLocked = lockVec[secIdx];                                     // [RULE5]
  wire       spanOk    = opStart_ff <= opEnd_ff;
  wire       overlap   = prot.valid && opStart_ff <= prot.hi && opEnd_ff >= prot.lo; // [RULE15]
  wire       opAllowed = writeEnableLatch_ff &&
                         (opSecReg ? !secLocked : (spanOk && !overlap));    // [RULE11] [RULE14]

  // read mux
  wire [31:0] statusWord = {16'h0000, pausedOpFlag_ff, invertProtection_ff, otpLockBits_ff,
                            1'b0, fourLaneEnable_ff, 1'b0, statusLockModeLow_ff,
                            smallGranuleSelect_ff, protectFromLowEnd_ff, protectRange_ff,
                            writeEnableLatch_ff, 1'b0};
  wire [31:0] linkWord   = {21'h000000, ~guardS_n, pauseActive, linkDrive_ff, rxShift_ff};
  wire [31:0] readMux    =
    (phaseAddr_ff == REG_STATUS)   ? statusWord :
    (phaseAddr_ff == REG_OP_START) ? {10'h000, opStart_ff} :
    (phaseAddr_ff == REG_OP_END)   ? {10'h000, opEnd_ff} :
    (phaseAddr_ff == REG_RESULT)   ? {29'h00000000, result_ff} :
    (phaseAddr_ff == REG_LINK)     ? linkWord : 32'h00000000;

  // bus outputs: reads take one wait state
  assign hreadyout = ~rdPend_ff;
  assign hrdata    = rdata_ff;
  assign hresp     = 1'b0;

  // link pins: data lanes only exist in four-lane mode
  assign dataLineTwoOut    = lineTwoOut_ff;
  assign dataLineThreeOut  = lineThreeOut_ff;
  assign dataLineTwoOe_n   = ~(fourLaneEnable_ff & linkDrive_ff);    // [RULE7]
  assign dataLineThreeOe_n = ~(fourLaneEnable_ff & linkDrive_ff);    // [RULE7]
  assign arrayWriteGo      = arrayGo_ff;
  assign arrayStart        = arrayStart_ff;
  assign arrayEnd          = arrayEnd_ff;

  // bus phase tracking
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_ff    <= 1'b0;
      rdPend_ff    <= 1'b0;
      phaseAddr_ff <= 8'h00;
      rdata_ff     <= 32'h00000000;
    end else begin
      wrPend_ff <= addrPhase & hwrite;
      rdPend_ff <= addrPhase & ~hwrite;
      if (addrPhase) phaseAddr_ff <= {haddr[7:2], 2'b00};
      if (rdPend_ff) rdata_ff <= readMux;
    end
  end

  // pin synchronisers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA_ff    <= 5'h06;
      syncB_ff    <= 5'h06;
      sclkPrev_ff <= 1'b0;
    end else begin
      syncA_ff    <= {dataLineThreeIn, dataLineTwoIn, pausePin_n, guardPin_n, serialClk};
      syncB_ff    <= syncA_ff;
      sclkPrev_ff <= sclkS;
    end
  end

  // paused flag, set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) pausedOpFlag_ff <= 1'b0;                             // [RULE2]
    else if (cmdSuspend) pausedOpFlag_ff <= 1'b1;                    // [RULE1]
    else if (cmdResume) pausedOpFlag_ff <= 1'b0;                     // [RULE2]
  end

  // write enable latch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) writeEnableLatch_ff <= 1'b0;
    else if (cmdWen) writeEnableLatch_ff <= 1'b1;
    else if (cmdWdis | statusTake | opGo) writeEnableLatch_ff <= 1'b0; // [RULE14]
  end

  // configuration fields written by the status write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      invertProtection_ff   <= 1'b0;
      otpLockBits_ff        <= '0;                                   // [RULE3]
      fourLaneEnable_ff     <= 1'b0;                                 // [RULE6]
      statusLockModeLow_ff  <= 1'b0;
      smallGranuleSelect_ff <= 1'b0;
      protectFromLowEnd_ff  <= 1'b0;
      protectRange_ff       <= RANGE_NONE;                           // [RULE12]
    end else if (statusTake) begin
      invertProtection_ff   <= hwdata[BIT_INVERT];                   // [RULE13]
      otpLockBits_ff        <= otpLockBits_ff | hwdata[LOCK_LSB +: LOCK_W]; // [RULE4]
      fourLaneEnable_ff     <= hwdata[BIT_FOUR_LANE];
      statusLockModeLow_ff  <= hwdata[BIT_STATUS_LOCK];
      smallGranuleSelect_ff <= hwdata[BIT_SMALL];
      protectFromLowEnd_ff  <= hwdata[BIT_LOW_END];
      protectRange_ff       <= hwdata[RANGE_LSB +: RANGE_W];         // [RULE12]
    end
  end

  // operation span registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opStart_ff <= '0;
      opEnd_ff   <= '0;
    end else begin
      if (regStart) opStart_ff <= hwdata[ADDR_W-1:0];
      if (regEnd) opEnd_ff <= hwdata[ADDR_W-1:0];
    end
  end

  // verdict and release of the operation to the array
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_ff     <= 3'h0;
      arrayGo_ff    <= 1'b0;
      arrayStart_ff <= '0;
      arrayEnd_ff   <= '0;
    end else begin
      arrayGo_ff <= opGo & opAllowed & ~opSecReg;                    // [RULE11]
      if (opGo) begin
        result_ff     <= {~opAllowed, opAllowed, 1'b1};
        arrayStart_ff <= opSecReg ? '0 : opStart_ff;
        arrayEnd_ff   <= opSecReg ? '0 : opEnd_ff;
      end
    end
  end

  // link lanes on serial clock edges, frozen while paused
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txBits_ff       <= 2'h0;
      linkDrive_ff    <= 1'b0;
      rxShift_ff      <= 8'h00;
      lineTwoOut_ff   <= 1'b0;
      lineThreeOut_ff <= 1'b0;
    end else begin
      if (regLink) begin
        txBits_ff    <= hwdata[1:0];
        linkDrive_ff <= hwdata[BIT_LINK_DRV];
      end
      if (sclkRise & fourLaneEnable_ff) rxShift_ff <= {rxShift_ff[5:0], lineThreeS, lineTwoS};
      if (sclkFall & ~pauseActive) begin
        lineTwoOut_ff   <= txBits_ff[0];
        lineThreeOut_ff <= txBits_ff[1];
      end
    end
  end

  // checks
  a_suspend_sets: assert property (@(posedge clk) disable iff (!rst_n) // [RULE1]
    cmdSuspend |=> pausedOpFlag_ff && statusWord[BIT_PAUSED])
    else $error("suspend did not set paused flag");

  a_resume_clears: assert property (@(posedge clk) disable iff (!rst_n) // [RULE2]
    cmdResume |=> !pausedOpFlag_ff)
    else $error("resume did not clear paused flag");

  a_lock_sticky: assert property (@(posedge clk) disable iff (!rst_n) // [RULE4]
    ($past(otpLockBits_ff) & ~otpLockBits_ff) == '0)
    else $error("lock bit returned to zero");

  a_locked_refused: assert property (@(posedge clk) disable iff (!rst_n) // [RULE5]
    (opGo && opSecReg && secLocked) |=> result_ff[BIT_RES_BAD] && !arrayGo_ff)
    else $error("locked security register accepted");

  a_lanes_released: assert property (@(posedge clk) disable iff (!rst_n) // [RULE7]
    !fourLaneEnable_ff |-> dataLineTwoOe_n && dataLineThreeOe_n && !pauseActive == pauseS_n)
    else $error("data lanes driven outside four-lane mode");

  a_range_all: assert property (@(posedge clk) disable iff (!rst_n) // [RULE9]
    (protectRange_ff == RANGE_ALL && !invertProtection_ff) |->
      prot.valid && prot.lo == '0 && prot.hi == ADDR_W'(ARRAY_BYTES - 23'h1))
    else $error("all-array code decoded wrongly");

  a_small_top: assert property (@(posedge clk) disable iff (!rst_n) // [RULE10]
    (protectRange_ff == 3'h1 && smallGranuleSelect_ff && !protectFromLowEnd_ff &&
     !invertProtection_ff) |-> prot.lo == ADDR_W'(ARRAY_BYTES - SECTOR_BYTES))
    else $error("smallest top window decoded wrongly");

  a_overlap_drops: assert property (@(posedge clk) disable iff (!rst_n) // [RULE11]
    (opGo && !opSecReg && overlap) |=> !arrayGo_ff ##1 !arrayGo_ff)
    else $error("protected span reached the array");

  a_invert_all: assert property (@(posedge clk) disable iff (!rst_n) // [RULE13]
    (protectRange_ff == RANGE_ALL && invertProtection_ff) |-> !prot.valid)
    else $error("inverted all-array still protects");

  a_wel_needed: assert property (@(posedge clk) disable iff (!rst_n) // [RULE14]
    (regStatus && !writeEnableLatch_ff) |=> $stable(protectRange_ff))
    else $error("status write taken without write enable");

endmodule : fspd_status_protect

// ===== verification/fspd_link_host.sv
// fspd_link_host: host side of the serial link pins.
// assumes the bench starts each frame and picks the pin levels.
`timescale 1ns/1ps
module fspd_link_host (
  // frame control from the bench
  input  wire logic       frameGo,
  input  wire logic [1:0] txLanes,
  input  wire logic       guardLow,
  input  wire logic       pauseLow,
  // device lane drivers
  input  wire logic [1:0] devOut,
  input  wire logic [1:0] devOe_n,
  // pins
  output logic            serialClk,
  output logic            guardPin_n,
  output logic            pausePin_n,
  output logic [1:0]      laneWire,
  // lanes seen at the last rising edge
  output logic [1:0]      rxLanes
);
  logic [1:0] hostDrv;

  // pins are driven by the host, never strapped to a rail
  assign guardPin_n = ~guardLow;
  assign pausePin_n = ~pauseLow;

  // wire level from the device enables; the host drives whenever the device does not
  assign laneWire[0] = devOe_n[0] ? hostDrv[0] : devOut[0];
  assign laneWire[1] = devOe_n[1] ? hostDrv[1] : devOut[1];

  // serial clock idles low outside frames
  initial begin
    serialClk = 1'b0;
    hostDrv   = 2'h0;
    rxLanes   = 2'h0;
  end

  // four clocks per frame; idle lanes show the inverse afterwards
  always @(posedge frameGo) begin
    hostDrv = txLanes;
    repeat (4) begin
      #100 serialClk = 1'b1;
      rxLanes = laneWire;
      #100 serialClk = 1'b0;
    end
    hostDrv = ~txLanes;
  end
endmodule : fspd_link_host

// ===== verification/tb_top.sv
// tb_top: self-checking bench for the status and protection block.
// assumes one ahb-lite slave and the link host model beside it.
`timescale 1ns/1ps
module tb_top;
  import fspd_pkg::*;
  // bus, pins and bookkeeping
  logic              clk, rst_n, hsel, hwrite, hreadyout, hresp;
  logic [1:0]        htrans, txLanes, devOut, devOe_n, laneWire, rxLanes;
  logic [2:0]        hsize;
  logic [31:0]       haddr, hwdata, hrdata, rdv, sw;
  logic              serialClk, guardPin_n, pausePin_n, frameGo;
  logic              guardLow, pauseLow, arrayWriteGo;
  logic [ADDR_W-1:0] arrayStart, arrayEnd, s, e;
  int                bad_count = 0, tests_run = 0, goCount = 0;

  fspd_status_protect u_fspd_status_protect (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .serialClk(serialClk),
    .guardPin_n(guardPin_n), .pausePin_n(pausePin_n), .dataLineTwoIn(laneWire[0]),
    .dataLineTwoOut(devOut[0]), .dataLineTwoOe_n(devOe_n[0]),
    .dataLineThreeIn(laneWire[1]), .dataLineThreeOut(devOut[1]),
    .dataLineThreeOe_n(devOe_n[1]), .arrayWriteGo(arrayWriteGo),
    .arrayStart(arrayStart), .arrayEnd(arrayEnd));

  fspd_link_host u_fspd_link_host (
    .frameGo(frameGo), .txLanes(txLanes), .guardLow(guardLow), .pauseLow(pauseLow),
    .devOut(devOut), .devOe_n(devOe_n), .serialClk(serialClk),
    .guardPin_n(guardPin_n), .pausePin_n(pausePin_n), .laneWire(laneWire),
    .rxLanes(rxLanes));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // counts accepted array operations
  always @(posedge clk) if (arrayWriteGo === 1'b1) goCount++;

  // compare and report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    if (bad_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  // next edge with hready high, bounded
  task automatic waitRdy;
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        bad_count++;
        report_and_stop;
      end
      @(posedge clk);
    end
  endtask : waitRdy

  // one single word transfer
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    waitRdy;
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy;
    rdv = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask : rd

  // write enable first, then the status word
  task automatic setStat(input logic [31:0] v);
    wr(REG_CMD, {24'h0, CMD_WRITE_ENABLE});
    wr(REG_STATUS, v);
  endtask : setStat

  // one program or erase request and its outcome
  task automatic runOp(input logic [21:0] st, en, input logic [3:0] ctl, input logic ok);
    int g0;
    wr(REG_CMD, {24'h0, CMD_WRITE_ENABLE});
    wr(REG_OP_START, {10'h0, st});
    wr(REG_OP_END, {10'h0, en});
    g0 = goCount;
    wr(REG_OP_CTRL, {28'h0, ctl});
    rd(REG_RESULT);
    check(rdv, ok ? 32'h3 : 32'h5);
    check(hresp, 1'b0);
    check(goCount - g0, ok && ctl == 4'h1);
    if (ok && ctl == 4'h1) begin
      check(arrayStart, st);
      check(arrayEnd, en);
    end
  endtask : runOp

  // one link frame, then let the synchronisers settle
  task automatic frame(input logic [1:0] t);
    txLanes <= t;
    frameGo <= 1'b1;
    @(posedge clk);
    frameGo <= 1'b0;
    repeat (40) @(posedge clk);
  endtask : frame

  // does span a..b meet a protected byte
  function automatic logic hits(input logic [31:0] w, input logic [21:0] a, b);
    logic [2:0]  r;
    logic [22:0] sz, lo, hi;
    r  = w[4:2];
    sz = w[6] ? SECTOR_BYTES << (r > 3'h3 ? 3 : r - 1) : BLOCK_BYTES << (r - 1);
    lo = w[5] ? 23'h0 : ARRAY_BYTES - sz;
    hi = w[5] ? sz - 1 : ARRAY_BYTES - 1;
    if (r == RANGE_NONE || r == RANGE_ALL) return w[14] ^ (r == RANGE_ALL);
    if (w[14]) return a < lo || b > hi;
    return a <= hi && b >= lo;
  endfunction : hits

  // main sequence
  initial begin
    {rst_n, hsel, hwrite, frameGo, guardLow, pauseLow} = 6'h10;
    {htrans, hsize, txLanes} = 7'h08;
    {haddr, hwdata} = 64'h0;
    rdv = $urandom(65);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(REG_STATUS);
    check(rdv, 32'h0);
    wr(REG_CMD, {24'h0, CMD_SUSPEND});
    rd(REG_STATUS);
    check(rdv, 32'h8000);
    setStat(32'h0);
    rd(REG_STATUS);
    check(rdv, 32'h8000);
    wr(REG_CMD, {24'h0, CMD_RESUME});
    rd(REG_STATUS);
    check(rdv, 32'h0);
    wr(REG_CMD, {24'h0, CMD_SUSPEND});
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    rd(REG_STATUS);
    check(rdv, 32'h0);
    // status write without write enable is ignored
    wr(REG_STATUS, 32'h1c);
    rd(REG_STATUS);
    check(rdv, 32'h0);
    // lock one security register, try to unlock it
    setStat(32'h1000);
    setStat(32'h0);
    rd(REG_STATUS);
    check(rdv, 32'h1000);
    runOp(22'h0, 22'h0, 4'hb, 1'b0);
    runOp(22'h0, 22'h0, 4'h7, 1'b1);
    runOp(22'h0, 22'h0, 4'h3, 1'b0);
    wr(REG_OP_CTRL, 32'h1);
    rd(REG_RESULT);
    check(rdv, 32'h5);
    // every protect code, both ends, both granules, inverted or not
    for (int c = 0; c < 64; c++) begin
      sw = 32'h0;
      sw[14] = c[5];
      sw[6:2] = c[4:0];
      setStat(sw);
      rd(REG_STATUS);
      check(rdv, sw | 32'h1000);
      for (int k = 0; k < 5; k++) begin
        s = (k == 1) ? '1 : (k == 0) ? '0 : 22'($urandom);
        e = (k < 2) ? s : s + 22'($urandom >> ($urandom % 3 * 5 + 10));
        runOp(s, e, 4'h1, s <= e && !hits(sw, s, e));
      end
    end
    // guard and pause pins with four-lane off
    guardLow <= 1'b1;
    pauseLow <= 1'b1;
    setStat(32'h80);
    setStat(32'h90);
    rd(REG_STATUS);
    check(rdv, 32'h1082);
    rd(REG_LINK);
    check(rdv[10:9], 2'h3);
    // four-lane on: guard and pause ignored, lanes carry data
    guardLow <= 1'b0;
    setStat(32'h280);
    guardLow <= 1'b1;
    setStat(32'h290);
    rd(REG_STATUS);
    check(rdv, 32'h1290);
    rd(REG_LINK);
    check(rdv[9], 1'b0);
    wr(REG_LINK, 32'h101);
    frame(2'h2);
    check(devOe_n, 2'h0);
    check(rxLanes, 2'h1);
    wr(REG_LINK, 32'h0);
    frame(2'h2);
    rd(REG_LINK);
    check(rdv[7:0], 8'haa);
    check(devOe_n, 2'h3);
    // back to four-lane off: no lane drive
    wr(REG_LINK, 32'h100);
    setStat(32'h80);
    repeat (2) @(posedge clk);
    check(devOe_n, 2'h3);
    report_and_stop;
  end
endmodule : tb_top
